/* File: rtl/i2c_flags_consts.vh */
// Constants for the bus address and arbitration status flag block.
`ifndef I2C_FLAGS_CONSTS_VH
`define I2C_FLAGS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_STATUS    8'h00
`define OFS_CTRL      8'h04
`define OFS_PRIM_ADDR 8'h08
`define OFS_SEC_ADDR  8'h0C
`define OFS_DATA      8'h10
`define OFS_IRQ_STAT  8'h14
`define OFS_IRQ_MASK  8'h18

// ----------------------------------------
// Status and interrupt bit positions
// ----------------------------------------
`define BIT_SEC_MATCH 4
`define BIT_ARB_LOST  3
`define BIT_OWN_MATCH 2

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define BIT_MASTER    0
`define BIT_TRANSMIT  1
`define BIT_ARB_SEL   2
`define BIT_START_REQ 3

// ----------------------------------------
// Address register fields and values
// ----------------------------------------
`define BIT_FMT_SEL   0
`define ADDR_HI       7
`define ADDR_LO       1
`define GEN_CALL_BYTE 8'h00
`define FLAGS_RST     3'h0
`define BYTE_RST      8'h00
`define WORD_RST      32'h0000_0000
`define BIT_LAST      4'h7
`define BIT_ACK       4'h8

`endif

/* File: rtl/pin_sync.v */
// Two flip-flop synchroniser for the bus pins.
module pin_sync #(
    parameter WIDTH = 2
) (
    input  wire             clk_sys_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // Idle bus lines are high, so reset to high to avoid a false start.
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

/* File: rtl/frame_rx.v */
// Bus condition detector and frame shifter working on synchronised pins.
`include "i2c_flags_consts.vh"
module frame_rx (
    input  wire       clk_sys_in,
    input  wire       rstn_in,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       scl_rise_out,
    output wire       scl_fall_out,
    output wire       sda_fall_out,
    output wire       start_out,
    output reg        frame_done_out,
    output reg        first_frame_out,
    output reg  [7:0] frame_out
);
    reg       scl_prev_ff;
    reg       sda_prev_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg       first_ff;
    wire      stop;

    assign scl_rise_out = scl_in & ~scl_prev_ff;
    assign scl_fall_out = ~scl_in & scl_prev_ff;
    assign sda_fall_out = ~sda_in & sda_prev_ff;
    assign start_out    = sda_fall_out & scl_in & scl_prev_ff;
    assign stop         = sda_in & ~sda_prev_ff & scl_in & scl_prev_ff;

    // The ninth clock carries the acknowledge and is counted but not shifted.
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            scl_prev_ff     <= 1'b1;
            sda_prev_ff     <= 1'b1;
            bit_cnt_ff      <= 4'h0;
            shift_ff        <= `BYTE_RST;
            first_ff        <= 1'b0;
            frame_done_out  <= 1'b0;
            first_frame_out <= 1'b0;
            frame_out       <= `BYTE_RST;
        end else begin
            scl_prev_ff     <= scl_in;
            sda_prev_ff     <= sda_in;
            frame_done_out  <= 1'b0;
            first_frame_out <= 1'b0;
            if (start_out) begin
                bit_cnt_ff <= 4'h0;
                first_ff   <= 1'b1;
            end else if (stop) begin
                bit_cnt_ff <= 4'h0;
                first_ff   <= 1'b0;
            end else if (scl_rise_out) begin
                if (bit_cnt_ff == `BIT_ACK) begin
                    bit_cnt_ff <= 4'h0;
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    shift_ff   <= {shift_ff[6:0], sda_in};
                end
                if (bit_cnt_ff == `BIT_LAST) begin
                    frame_done_out  <= 1'b1;
                    first_frame_out <= first_ff;
                    first_ff        <= 1'b0;
                    frame_out       <= {shift_ff[6:0], sda_in};
                end
            end
        end
    end
endmodule

/* File: rtl/i2c_addr_flags.v */
// Address recognition and arbitration lost status flags with an APB slave.
//
// Notes on behaviour
// - As slave receiver, the first frame after a start that equals the second address sets its match flag.
// - The second-address match flag is set only as slave receiver with its format select at 0.
// - Writing 0 to the second-address match flag after reading it as 1 clears it.
// - Any start condition on the bus clears the second-address match flag.
// - An arbitration-lost flag reports loss of the bus while acting as master.
// - As master transmitter, own data level unequal to the data pin at a clock rise sets arbitration lost.
// - With arbitration select 0, own clock still high at a bus clock fall in master mode sets arbitration lost.
// - With arbitration select 1, as master transmitter, another device pulling data low first after a start request sets it.
// - A data write in transmit mode or a data read in receive mode clears arbitration lost and own match.
// - Writing 0 to arbitration lost after reading it as 1 clears it.
// - As slave receiver, a first frame matching the own address, or a whole frame of 00, sets own match.
// - The own-address match flag is set only as slave receiver with the primary format select at 0.
// - Writing 0 to the own-address match flag after reading it as 1 clears it.
`include "i2c_flags_consts.vh"
module i2c_addr_flags (
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire        scl_in,
    input  wire        sda_in,
    input  wire        int_scl_in,
    input  wire        int_sda_in,
    output reg         irq_out,
    output reg         second_addr_match_flag_out,
    output reg         arbitration_lost_flag_out,
    output reg         own_addr_match_flag_out
);
    // ----------------------------------------
    // Pin synchronisation and bus conditions
    // ----------------------------------------
    wire [1:0] pins_sync;
    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       sda_fall;
    wire       start_det;
    wire       frame_done;
    wire       first_frame;
    wire [7:0] frame;

    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .async_in   ({scl_in, sda_in}),
        .sync_out   (pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    frame_rx u_rx (
        .clk_sys_in      (clk_sys_in),
        .rstn_in         (rstn_in),
        .scl_in          (scl_s),
        .sda_in          (sda_s),
        .scl_rise_out    (scl_rise),
        .scl_fall_out    (scl_fall),
        .sda_fall_out    (sda_fall),
        .start_out       (start_det),
        .frame_done_out  (frame_done),
        .first_frame_out (first_frame),
        .frame_out       (frame)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg        master_ff;
    reg        transmit_ff;
    reg        arb_detect_select_ff;
    reg        start_pending_ff;
    reg  [7:0] primary_slave_addr_reg_ff;
    reg  [7:0] second_slave_addr_reg_ff;
    reg  [7:0] bus_data_reg_ff;
    reg  [2:0] armed_ff;
    reg  [2:0] irq_stat_ff;
    reg  [2:0] irq_mask_ff;
    reg        sec_flag_ff;
    reg        arb_flag_ff;
    reg        own_flag_ff;
    reg  [2:0] nxt_armed;
    reg        nxt_sec;
    reg        nxt_arb;
    reg        nxt_own;

    // Packs the three flags into the status word layout.
    function [31:0] pack_flags;
        input [2:0] f;
        begin
            pack_flags                 = `WORD_RST;
            pack_flags[`BIT_SEC_MATCH] = f[2];
            pack_flags[`BIT_ARB_LOST]  = f[1];
            pack_flags[`BIT_OWN_MATCH] = f[0];
        end
    endfunction

    // Picks the three flag bits out of a written word.
    function [2:0] unpack_flags;
        input [31:0] w;
        begin
            unpack_flags = {w[`BIT_SEC_MATCH], w[`BIT_ARB_LOST], w[`BIT_OWN_MATCH]};
        end
    endfunction

    // One wait state: the access completes in the second access cycle.
    wire access = psel_in & penable_in & pready_out;
    wire wr     = access & pwrite_in;
    wire rd     = access & ~pwrite_in;
    wire mapped = (paddr_in == `OFS_STATUS) || (paddr_in == `OFS_CTRL) ||
                  (paddr_in == `OFS_PRIM_ADDR) || (paddr_in == `OFS_SEC_ADDR) ||
                  (paddr_in == `OFS_DATA) || (paddr_in == `OFS_IRQ_STAT) ||
                  (paddr_in == `OFS_IRQ_MASK);

    wire [2:0] flags   = {sec_flag_ff, arb_flag_ff, own_flag_ff};
    wire [2:0] wr_bits = unpack_flags(pwdata_in);
    wire       st_wr   = wr && (paddr_in == `OFS_STATUS);
    wire       st_rd   = rd && (paddr_in == `OFS_STATUS);
    wire       data_wr = wr && (paddr_in == `OFS_DATA);
    wire       data_rd = rd && (paddr_in == `OFS_DATA);
    wire       data_clr = (data_wr & transmit_ff) | (data_rd & ~transmit_ff);

    // ----------------------------------------
    // Flag set conditions
    // ----------------------------------------
    wire slave_rx = ~master_ff & first_frame;
    wire prim_fmt = primary_slave_addr_reg_ff[`BIT_FMT_SEL];
    wire sec_fmt  = second_slave_addr_reg_ff[`BIT_FMT_SEL];
    wire [6:0] prim_addr = primary_slave_addr_reg_ff[`ADDR_HI:`ADDR_LO];
    wire [6:0] sec_addr  = second_slave_addr_reg_ff[`ADDR_HI:`ADDR_LO];

    wire set_sec = slave_rx & ~sec_fmt & (frame[7:1] == sec_addr);
    wire set_own = slave_rx & ~prim_fmt &
                   ((frame[7:1] == prim_addr) || (frame == `GEN_CALL_BYTE));

    wire arb_data = master_ff & transmit_ff & scl_rise & (int_sda_in != sda_s);
    wire arb_clk  = ~arb_detect_select_ff & master_ff & scl_fall & int_scl_in;
    wire arb_strt = arb_detect_select_ff & master_ff & transmit_ff &
                    start_pending_ff & sda_fall & int_sda_in;
    wire set_arb  = arb_data | arb_clk | arb_strt;

    // ----------------------------------------
    // Flag next state
    // ----------------------------------------
    // A set in the same cycle as any clear wins, so no event is lost.
    always @* begin
        nxt_armed = armed_ff;
        nxt_sec   = sec_flag_ff;
        nxt_arb   = arb_flag_ff;
        nxt_own   = own_flag_ff;
        // A status write may only clear a flag that an earlier read returned as 1.
        if (st_rd) begin
            nxt_armed = armed_ff | unpack_flags(prdata_out); // Arm what the completing read returned, not a later set.
        end
        if (st_wr) begin
            nxt_armed = 3'h0;
            if (armed_ff[2] && !wr_bits[2]) begin
                nxt_sec = 1'b0;
            end
            if (armed_ff[1] && !wr_bits[1]) begin
                nxt_arb = 1'b0;
            end
            if (armed_ff[0] && !wr_bits[0]) begin
                nxt_own = 1'b0;
            end
        end
        if (start_det) begin
            nxt_sec = 1'b0;
        end
        if (data_clr) begin
            nxt_arb = 1'b0;
            nxt_own = 1'b0;
        end
        if (set_sec) begin
            nxt_sec = 1'b1;
        end
        if (set_arb) begin
            nxt_arb = 1'b1;
        end
        if (set_own) begin
            nxt_own = 1'b1;
        end
    end

    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            sec_flag_ff <= 1'b0;
            arb_flag_ff <= 1'b0;
            own_flag_ff <= 1'b0;
            armed_ff    <= 3'h0;
        end else begin
            sec_flag_ff <= nxt_sec;
            arb_flag_ff <= nxt_arb;
            own_flag_ff <= nxt_own;
            armed_ff    <= nxt_armed;
        end
    end

    // ----------------------------------------
    // Control, address and data registers
    // ----------------------------------------
    // The start request stays pending until the device itself pulls data low, master mode is left or arbitration is lost.
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            master_ff                 <= 1'b0;
            transmit_ff               <= 1'b0;
            arb_detect_select_ff      <= 1'b0;
            start_pending_ff          <= 1'b0;
            primary_slave_addr_reg_ff <= `BYTE_RST;
            second_slave_addr_reg_ff  <= `BYTE_RST;
            bus_data_reg_ff           <= `BYTE_RST;
        end else begin
            if (wr && (paddr_in == `OFS_CTRL)) begin
                master_ff            <= pwdata_in[`BIT_MASTER];
                transmit_ff          <= pwdata_in[`BIT_TRANSMIT];
                arb_detect_select_ff <= pwdata_in[`BIT_ARB_SEL];
            end
            if (wr && (paddr_in == `OFS_CTRL) && pwdata_in[`BIT_START_REQ]) begin
                start_pending_ff <= 1'b1;
            end else if (!int_sda_in || !master_ff || set_arb) begin
                start_pending_ff <= 1'b0;
            end
            if (wr && (paddr_in == `OFS_PRIM_ADDR)) begin
                primary_slave_addr_reg_ff <= pwdata_in[7:0];
            end
            if (wr && (paddr_in == `OFS_SEC_ADDR)) begin
                second_slave_addr_reg_ff <= pwdata_in[7:0];
            end
            // A received frame takes priority over a software write.
            if (frame_done) begin
                bus_data_reg_ff <= frame;
            end else if (data_wr) begin
                bus_data_reg_ff <= pwdata_in[7:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    wire [2:0] irq_events = {set_sec, set_arb, set_own};
    wire [2:0] irq_w1c    = (wr && (paddr_in == `OFS_IRQ_STAT)) ? wr_bits : 3'h0;

    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            irq_out     <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_events;
            if (wr && (paddr_in == `OFS_IRQ_MASK)) begin
                irq_mask_ff <= wr_bits;
            end
            irq_out <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ----------------------------------------
    // APB slave response
    // ----------------------------------------
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= `WORD_RST;
        end else begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
            prdata_out  <= `WORD_RST;
            if (psel_in && penable_in && !pready_out && !pwrite_in) begin
                if (paddr_in == `OFS_STATUS) begin
                    prdata_out <= pack_flags(flags);
                end else if (paddr_in == `OFS_CTRL) begin
                    prdata_out <= {28'h0000000, start_pending_ff, arb_detect_select_ff,
                                   transmit_ff, master_ff};
                end else if (paddr_in == `OFS_PRIM_ADDR) begin
                    prdata_out <= {24'h000000, primary_slave_addr_reg_ff};
                end else if (paddr_in == `OFS_SEC_ADDR) begin
                    prdata_out <= {24'h000000, second_slave_addr_reg_ff};
                end else if (paddr_in == `OFS_DATA) begin
                    prdata_out <= {24'h000000, bus_data_reg_ff};
                end else if (paddr_in == `OFS_IRQ_STAT) begin
                    prdata_out <= pack_flags(irq_stat_ff);
                end else if (paddr_in == `OFS_IRQ_MASK) begin
                    prdata_out <= pack_flags(irq_mask_ff);
                end
            end
        end
    end

    // ----------------------------------------
    // Flag outputs
    // ----------------------------------------
    // Registered copies lag the internal flags by one cycle.
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            second_addr_match_flag_out <= 1'b0;
            arbitration_lost_flag_out  <= 1'b0;
            own_addr_match_flag_out    <= 1'b0;
        end else begin
            second_addr_match_flag_out <= sec_flag_ff;
            arbitration_lost_flag_out  <= arb_flag_ff;
            own_addr_match_flag_out    <= own_flag_ff;
        end
    end
endmodule

/* File: testbench/i2c_bus_model.sv */
// Behavioural bus master that drives the clock and data pins of the bus.
module i2c_bus_model (
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // A quarter of the 160 ns link clock period.
    localparam time QTR = 40ns;

    // Both lines are open drain: 1 releases the line to its pull-up.
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // --------------------------------------------
    // Bus conditions and frames
    // --------------------------------------------
    // The 3 ns lead keeps pin edges off the system clock edge, so the result never depends on process order.
    task automatic start_cond();
        #3ns;
        sda_out = 1'b0;
        #QTR;
        scl_out = 1'b0;
        #QTR;
    endtask

    // Eight data bits, most significant first, then an acknowledge clock with data released.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_out = (i > 0) ? b[i-1] : 1'b1;
            #QTR;
            scl_out = 1'b1;
            #(2 * QTR);
            scl_out = 1'b0;
            #QTR;
        end
    endtask

    task automatic stop_cond();
        sda_out = 1'b0;
        #QTR;
        scl_out = 1'b1;
        #QTR;
        sda_out = 1'b1;
        #QTR;
    endtask

    // Returns to idle without a stop, so no clock rise is seen with data low.
    task automatic release_bus();
        sda_out = 1'b1;
        #QTR;
        scl_out = 1'b1;
        #QTR;
    endtask
endmodule

/* File: testbench/i2c_addr_flags_sva.sv */
// Assertion checker for the address and arbitration status flags.
`include "i2c_flags_consts.vh"
module i2c_addr_flags_sva (
    input wire        clk_sys_in,
    input wire        rstn_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [7:0]  paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        scl_in,
    input wire        sda_in,
    input wire        second_addr_match_flag_out,
    input wire        arbitration_lost_flag_out,
    input wire        own_addr_match_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------
    // Mirrors of the fields the flags depend on
    // --------------------------------------------
    reg  [2:0] armed_ff;
    reg        mst_ff;
    reg        tx_ff;
    reg        pfmt_ff;
    reg        sfmt_ff;
    wire       done     = psel_in && penable_in && pready_out;
    wire       wr_st    = done && pwrite_in && paddr_in == `OFS_STATUS;
    wire       data_clr = done && paddr_in == `OFS_DATA && pwrite_in == tx_ff;
    wire [2:0] clr_mask = armed_ff & ~pwdata_in[4:2];
    wire [2:0] flags    = {second_addr_match_flag_out, arbitration_lost_flag_out, own_addr_match_flag_out};

    // Armed bits only grow between status writes, so a clear is demanded only after a read showed a one.
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            armed_ff <= 3'h0;
            mst_ff   <= 1'b0;
            tx_ff    <= 1'b0;
            pfmt_ff  <= 1'b0;
            sfmt_ff  <= 1'b0;
        end else begin
            if (wr_st)
                armed_ff <= 3'h0;
            else if (done && !pwrite_in && paddr_in == `OFS_STATUS)
                armed_ff <= armed_ff | prdata_out[4:2];
            if (done && pwrite_in && paddr_in == `OFS_CTRL) begin
                mst_ff <= pwdata_in[`BIT_MASTER];
                tx_ff  <= pwdata_in[`BIT_TRANSMIT];
            end
            if (done && pwrite_in && paddr_in == `OFS_PRIM_ADDR)
                pfmt_ff <= pwdata_in[`BIT_FMT_SEL];
            if (done && pwrite_in && paddr_in == `OFS_SEC_ADDR)
                sfmt_ff <= pwdata_in[`BIT_FMT_SEL];
        end
    end

    // --------------------------------------------
    // Properties
    // --------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    a_reset_flags_low: assert property ($rose(rstn_in) |-> flags == 3'h0)
        else $error("Status flags not zero after reset release");
    a_write_one_keeps: assert property (
        wr_st && pwdata_in[2] && own_addr_match_flag_out |=> ##1 own_addr_match_flag_out)
        else $error("Own match flag changed by a write of one");
    a_armed_zero_clears: assert property (
        wr_st && clr_mask != 3'h0 |=> ##1 (flags & $past(clr_mask, 2)) == 3'h0)
        else $error("Armed flag not cleared by a write of zero");
    a_data_clears: assert property (
        data_clr |=> ##1 !arbitration_lost_flag_out && !own_addr_match_flag_out)
        else $error("Data access did not clear the flags");
    a_start_clears_sec: assert property (
        second_addr_match_flag_out && scl_in && $fell(sda_in) |-> ##[1:10] !second_addr_match_flag_out)
        else $error("Start condition did not clear second match");
    a_own_slave_fmt: assert property ($rose(own_addr_match_flag_out) |-> !mst_ff && !pfmt_ff)
        else $error("Own match set outside slave bus format");
    a_sec_slave_fmt: assert property ($rose(second_addr_match_flag_out) |-> !mst_ff && !sfmt_ff)
        else $error("Second match set outside slave bus format");
    a_arb_master_only: assert property ($rose(arbitration_lost_flag_out) |-> $past(mst_ff))
        else $error("Arbitration lost set outside master mode");
endmodule

/* File: testbench/tb_top.sv */
// Testbench for the address and arbitration status flag block.
`include "i2c_flags_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_in = 1'b0;
    logic        rstn_in    = 1'b0;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [7:0]  paddr_in   = 8'h00;
    logic [31:0] pwdata_in  = 32'h0;
    logic        int_scl_in = 1'b1;
    logic        int_sda_in = 1'b1;
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, irq_out, sec_flag, arb_flag, own_flag, bus_scl, bus_sda;
    int          fail_count = 0;
    int          checks     = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    i2c_bus_model u_bus (.scl_out(bus_scl), .sda_out(bus_sda));

    i2c_addr_flags u_i2c_addr_flags (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .scl_in(bus_scl & int_scl_in),
        .sda_in(bus_sda & int_sda_in), .int_scl_in(int_scl_in), .int_sda_in(int_sda_in), .irq_out(irq_out),
        .second_addr_match_flag_out(sec_flag), .arbitration_lost_flag_out(arb_flag),
        .own_addr_match_flag_out(own_flag));

    // --------------------------------------------
    // Bus access and comparison helpers
    // --------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk_sys_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1);
        q = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic chk_st(input logic [2:0] e);
        logic [31:0] q;
        rd(`OFS_STATUS, q);
        check(q, {27'h0, e, 2'h0});
        check({29'h0, sec_flag, arb_flag, own_flag}, {29'h0, e});
    endtask

    // The interrupt output follows its status and mask one cycle later.
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk_sys_in);
        check({31'h0, irq_out}, {31'h0, e});
    endtask

    task automatic frame(input logic [7:0] b);
        u_bus.start_cond();
        u_bus.send_byte(b);
        u_bus.stop_cond();
        repeat (8) @(posedge clk_sys_in);
    endtask

    task automatic blip();
        u_bus.start_cond();
        u_bus.release_bus();
        repeat (8) @(posedge clk_sys_in);
    endtask

    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        chk_st(3'h0);
        apb(1'b0, 8'h1C, 32'h0, q, e);
        check(q, 32'h0);
        check({31'h0, e}, 32'h1);
        $display("Test reset done");
    endtask

    task automatic t_own();
        logic [31:0] q;
        wr(`OFS_SEC_ADDR, 32'hA3);
        wr(`OFS_PRIM_ADDR, 32'h55);
        frame(8'h54);
        chk_st(3'h0);
        wr(`OFS_PRIM_ADDR, 32'h54);
        frame(8'h56);
        chk_st(3'h0);
        frame(8'h54);
        chk_st(3'h1);
        chk_irq(1'b0);
        wr(`OFS_IRQ_MASK, 32'h4);
        chk_irq(1'b1);
        wr(`OFS_IRQ_STAT, 32'h4);
        chk_irq(1'b0);
        wr(`OFS_STATUS, 32'h1C);
        chk_st(3'h1);
        wr(`OFS_STATUS, 32'h0);
        chk_st(3'h0);
        frame(8'h00);
        chk_st(3'h1);
        rd(`OFS_DATA, q);
        chk_st(3'h0);
        $display("Test own address done");
    endtask

    task automatic t_sec();
        frame(8'hA2);
        chk_st(3'h0);
        wr(`OFS_SEC_ADDR, 32'hA2);
        frame(8'hA2);
        chk_st(3'h4);
        blip();
        chk_st(3'h0);
        frame(8'hA2);
        chk_st(3'h4);
        wr(`OFS_STATUS, 32'h0);
        chk_st(3'h0);
        $display("Test second address done");
    endtask

    task automatic t_arb();
        logic [31:0] q;
        wr(`OFS_CTRL, 32'h7);
        frame(8'h00);
        chk_st(3'h2);
        wr(`OFS_DATA, 32'h0);
        chk_st(3'h0);
        wr(`OFS_CTRL, 32'h1);
        blip();
        chk_st(3'h2);
        wr(`OFS_STATUS, 32'h0);
        chk_st(3'h0);
        wr(`OFS_CTRL, 32'hF);
        blip();
        chk_st(3'h2);
        rd(`OFS_DATA, q);
        chk_st(3'h2);
        wr(`OFS_DATA, 32'h0);
        chk_st(3'h0);
        wr(`OFS_CTRL, 32'h0);
        $display("Test arbitration done");
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        t_reset();
        t_own();
        t_sec();
        t_arb();
        summarize();
    end

    initial begin
        #300us;
        fail_count++;
        $display("Watchdog expired");
        summarize();
    end
endmodule

bind i2c_addr_flags i2c_addr_flags_sva u_sva (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .scl_in(scl_in), .sda_in(sda_in),
    .second_addr_match_flag_out(second_addr_match_flag_out),
    .arbitration_lost_flag_out(arbitration_lost_flag_out), .own_addr_match_flag_out(own_addr_match_flag_out));
